// *** logic/brs_pkg.sv ***
// Overview of operation
// - every listed reset source asserts reset
// - supply below minimum holds device in reset
// - power-up delay lasts a nominal 64 ms
// - reset held while power-up delay counts
// - delay enable bit is active low
// - delay starts after power and brown-out release
// - two-bit mode picks one of four behaviours
// - one bit selects brown-out trip level
// - only dips longer than filter time reset
// - mode 11: always on, start-up waits ready
// - always-on: sleep protected, wake not delayed
// - mode 10: off in sleep, start-up waits
// - off-in-sleep: wake waits for detector ready
// - mode 01: software enable, no start-up wait
// - software mode protects once ready, shows status
// - forced-on modes: ready before cpu runs
// - software enable bit acts only in mode 01
// - fast-start forces band gap in modes 10/01
// - read-only bit 0 shows detector ready
// - pin release after delay: run in 10 cycles
package brs_pkg;

  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned PUD_MS      = 64;
  localparam int unsigned PUD_CYC     = PUD_MS * 1000 * CLK_MHZ;
  localparam int unsigned EXIT_FOSC   = 10;
  localparam int unsigned SYNC_LAT    = 2;
  localparam int unsigned BO_FILT_NS  = 1000;
  localparam int unsigned BO_FILT_CYC = (BO_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BO_RDY_NS   = 800;
  localparam int unsigned BO_RDY_CYC  = (BO_RDY_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned CNT_W  = 24;
  localparam int unsigned RDY_W  = 8;
  localparam int unsigned FILT_W = 8;
  localparam int unsigned ADDR_W = 4;

  localparam logic [ADDR_W-1:0] BRC_OFF  = 4'h0;
  localparam int unsigned       SWEN_BIT = 7;
  localparam int unsigned       FS_BIT   = 6;
  localparam int unsigned       RDY_BIT  = 0;
  localparam logic              SWEN_RST = 1'b1;
  localparam logic              FS_RST   = 1'b0;

  localparam logic [1:0] MODE_ALWAYS  = 2'h3;
  localparam logic [1:0] MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] MODE_SW      = 2'h1;
  localparam logic [1:0] MODE_OFF     = 2'h0;

  typedef enum logic [2:0] {ST_POR, ST_PUD, ST_BOWAIT, ST_PIN, ST_EXIT, ST_RUN} brs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } brs_req_t;

  typedef struct packed {
    logic [1:0] brownout_mode_sel;
    logic       brownout_level_sel;
    logic       powerup_delay_disable_n;
    logic       pin_reset_en;
    logic       lp_brownout_en;
  } brs_cfg_t;

  typedef struct packed {
    logic wdt;
    logic instr;
    logic stk_ovf;
    logic stk_unf;
    logic prog_exit;
  } brs_src_t;

  typedef struct packed {
    brs_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic [RDY_W-1:0] rdy_cnt;
    logic             sw_en;
    logic             fs;
    logic [7:0]       rdata;
  } brs_core_t;

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
  } brs_filt_t;

  typedef struct packed {
    logic [SYNC_LAT-1:0] sh;
  } brs_sync_t;

  localparam brs_core_t CORE_RST = '{st: ST_POR, cnt: '0, rdy_cnt: '0,
                                     sw_en: SWEN_RST, fs: FS_RST, rdata: 8'h00};
  localparam brs_filt_t FILT_RST = '{cnt: '0};
  localparam brs_sync_t SYNC_RST = '{sh: '0};

endpackage

// *** logic/brs_filt.sv ***
`timescale 1ns/1ps
module brs_filt #(
  parameter int unsigned FILT_CYC = brs_pkg::BO_FILT_CYC
) (
  input  logic sys_clk_i,
  input  logic resetn_i,
  input  logic ce_i,
  input  logic below_i,
  output logic trip_o
);
  import brs_pkg::*;

  brs_filt_t q;
  brs_filt_t d;

  // counts earlier consecutive low cycles; saturates so long dips stay tripped
  always_comb begin
    d = q;
    if (!below_i) begin
      d.cnt = '0;
    end else if (q.cnt != FILT_W'(FILT_CYC)) begin
      d.cnt = q.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q <= FILT_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign trip_o = below_i && (q.cnt == FILT_W'(FILT_CYC));

  ////////////////////////////////////////////////////////////////////////////
  a_filt_short: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && !below_i) |=> !trip_o)
    else $error("filter tripped right after a clean cycle");

endmodule

// *** logic/brs_rsync.sv ***
`timescale 1ns/1ps
module brs_rsync (
  input  logic sys_clk_i,
  input  logic ce_i,
  input  logic rst_req_i,
  output logic rst_n_o
);
  import brs_pkg::*;

  brs_sync_t q;
  brs_sync_t d;

  always_comb begin
    d    = q;
    d.sh = {q.sh[SYNC_LAT-2:0], 1'b1};
  end

  // request clears at once; release walks through the stages on the clock
  always_ff @(posedge sys_clk_i or posedge rst_req_i) begin
    if (rst_req_i) begin
      q <= SYNC_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign rst_n_o = q.sh[SYNC_LAT-1];

  ////////////////////////////////////////////////////////////////////////////
  a_async_assert: assert property (@(posedge sys_clk_i)
    rst_req_i |-> !rst_n_o)
    else $error("reset request not seen on output");

  a_sync_release: assert property (@(posedge sys_clk_i)
    $rose(rst_n_o) |-> !$past(rst_req_i) && $past(q.sh[0]))
    else $error("reset released without a clean stage");

endmodule

// *** logic/brs_top.sv ***
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module brs_top #(
  parameter int unsigned PUD_CYC  = brs_pkg::PUD_CYC,
  parameter int unsigned FILT_CYC = brs_pkg::BO_FILT_CYC,
  parameter int unsigned RDY_CYC  = brs_pkg::BO_RDY_CYC,
  parameter int unsigned EXIT_CYC = brs_pkg::EXIT_FOSC
) (
  input  logic              sys_clk_i,
  input  logic              resetn_i,
  input  logic              ce_i,
  input  brs_pkg::brs_req_t reg_req_i,
  output logic [7:0]        reg_rdata_o,
  input  brs_pkg::brs_cfg_t cfg_i,
  input  logic              por_low_i,
  input  logic              vdd_below_i,
  input  logic              low_power_brownout_i,
  input  logic              external_reset_pin_n_i,
  input  brs_pkg::brs_src_t src_i,
  input  logic              sleep_i,
  output logic              cpu_rst_n_o,
  output logic              brownout_enable_o,
  output logic              brownout_level_sel_o,
  output logic              bandgap_force_on_o,
  output logic              brownout_circuit_ready_o,
  output logic              brownout_reset_o,
  output logic              wake_ok_o
);
  import brs_pkg::*;

  brs_core_t  q;
  brs_core_t  d;
  logic [1:0] mode;
  logic       bo_active;
  logic       fs_eff;
  logic       rdy;
  logic       filt_trip;
  logic       brownout_reset;
  logic       power_fail;
  logic       src_any;
  logic       pin_low;
  logic       needs_wait;
  logic       pud_en;
  logic       rst_req;
  logic       reg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // detector control

  assign mode = cfg_i.brownout_mode_sel;

  always_comb begin
    unique case (mode)
      MODE_ALWAYS:  bo_active = 1'b1;
      MODE_NOSLEEP: bo_active = !sleep_i;
      MODE_SW:      bo_active = q.sw_en;
      MODE_OFF:     bo_active = 1'b0;
    endcase
  end

  // band gap kept up so the detector comes back ready without a settle time
  assign fs_eff = q.fs && (mode == MODE_NOSLEEP || mode == MODE_SW);

  assign rdy = bo_active && (q.rdy_cnt == RDY_W'(RDY_CYC));

  // start-up waits on the detector only where it is forced on
  assign needs_wait = (mode == MODE_ALWAYS) || (mode == MODE_NOSLEEP);

  // wake from sleep: only the off-in-sleep mode must wait for readiness
  assign wake_ok_o = (mode != MODE_NOSLEEP) || rdy;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  brs_filt #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .below_i   (vdd_below_i && bo_active),
    .trip_o    (filt_trip)
  );

  // filtered trip protects only once the detector reports ready; low-power trip does not wait
  assign brownout_reset = (filt_trip && rdy) ||
                          (cfg_i.lp_brownout_en && low_power_brownout_i);

  // leaving programming mode behaves as a fresh power-on
  assign power_fail = por_low_i || brownout_reset || src_i.prog_exit;
  assign src_any    = src_i.wdt || src_i.instr || src_i.stk_ovf || src_i.stk_unf;
  assign pin_low    = cfg_i.pin_reset_en && !external_reset_pin_n_i;
  assign pud_en     = !cfg_i.powerup_delay_disable_n;

  // raw sources go straight in so assertion needs no clock edge
  assign rst_req = power_fail || src_any || pin_low || (q.st != ST_RUN);

  brs_rsync u_rsync (
    .sys_clk_i (sys_clk_i),
    .ce_i      (ce_i),
    .rst_req_i (rst_req),
    .rst_n_o   (cpu_rst_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer, readiness counter and control register

  assign reg_hit = (reg_req_i.addr == BRC_OFF);

  always_comb begin
    d       = q;
    d.rdata = 8'h00;

    // readiness: lost when powered down unless the band gap is held up
    if (bo_active) begin
      if (q.rdy_cnt != RDY_W'(RDY_CYC)) begin
        d.rdy_cnt = q.rdy_cnt + RDY_W'(1);
      end
    end else if (!fs_eff) begin
      d.rdy_cnt = '0;
    end

    if (power_fail) begin
      d.st  = ST_POR;
      d.cnt = '0;
    end else begin
      unique case (q.st)
        ST_POR: begin
          if (pud_en) begin
            d.st  = ST_PUD;
            d.cnt = CNT_W'(PUD_CYC - 1);
          end else begin
            d.st = ST_BOWAIT;
          end
        end
        ST_PUD: begin
          // pin is ignored here: the delay runs on its own
          if (q.cnt == '0) begin
            d.st = ST_BOWAIT;
          end else begin
            d.cnt = q.cnt - CNT_W'(1);
          end
        end
        ST_BOWAIT: begin
          if (!needs_wait || (rdy && !vdd_below_i)) begin
            d.st = ST_PIN;
          end
        end
        ST_PIN: begin
          if (!pin_low) begin
            d.st  = ST_EXIT;
            d.cnt = CNT_W'(EXIT_CYC - SYNC_LAT - 1);
          end
        end
        ST_EXIT: begin
          if (pin_low) begin
            d.st = ST_PIN;
          end else if (src_any) begin
            d.cnt = CNT_W'(EXIT_CYC - SYNC_LAT - 1);
          end else if (q.cnt == '0) begin
            d.st = ST_RUN;
          end else begin
            d.cnt = q.cnt - CNT_W'(1);
          end
        end
        ST_RUN: begin
          if (pin_low) begin
            d.st = ST_PIN;
          end else if (src_any) begin
            d.st  = ST_EXIT;
            d.cnt = CNT_W'(EXIT_CYC - SYNC_LAT - 1);
          end
        end
        default: begin
          d.st = ST_POR;
        end
      endcase
    end

    // both bits stay writable in every mode; their effect is gated above
    if (reg_req_i.wr && reg_hit) begin
      d.sw_en = reg_req_i.wdata[SWEN_BIT];
      d.fs    = reg_req_i.wdata[FS_BIT];
    end

    if (reg_req_i.rd && reg_hit) begin
      d.rdata[SWEN_BIT] = q.sw_en;
      d.rdata[FS_BIT]   = q.fs;
      d.rdata[RDY_BIT]  = rdy;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q <= CORE_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o              = q.rdata;
  assign brownout_enable_o        = bo_active;
  assign brownout_level_sel_o     = cfg_i.brownout_level_sel;
  assign bandgap_force_on_o       = fs_eff || bo_active;
  assign brownout_circuit_ready_o = rdy;
  assign brownout_reset_o         = brownout_reset;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_src_resets: assert property (
    (src_any || pin_low) |-> !cpu_rst_n_o)
    else $error("reset source did not hold cpu in reset");

  a_por_holds: assert property (
    por_low_i && ce_i |=> q.st == ST_POR && !cpu_rst_n_o)
    else $error("low supply did not hold reset");

  a_pud_load: assert property (
    (q.st == ST_POR && ce_i && !power_fail && pud_en)
    |=> q.st == ST_PUD && q.cnt == CNT_W'(PUD_CYC - 1))
    else $error("power-up delay loaded wrong count");

  a_pud_end: assert property (
    (q.st == ST_PUD && q.cnt == '0 && ce_i && !power_fail) |=> q.st == ST_BOWAIT)
    else $error("power-up delay did not end at zero");

  a_pud_holds: assert property (
    q.st == ST_PUD |-> !cpu_rst_n_o && !$past(cpu_rst_n_o))
    else $error("cpu released during power-up delay");

  a_pud_skip: assert property (
    (q.st == ST_POR && ce_i && !power_fail && !pud_en) |=> q.st == ST_BOWAIT)
    else $error("disabled power-up delay still ran");

  a_pud_start: assert property (
    (q.st == ST_POR && ce_i && power_fail) |=> q.st == ST_POR)
    else $error("delay left start state while supply faulted");

  a_mode_fixed: assert property (
    (mode == MODE_ALWAYS |-> brownout_enable_o) and (mode == MODE_OFF |-> !brownout_enable_o))
    else $error("fixed mode detector enable wrong");

  a_wait_ready: assert property (
    (q.st == ST_BOWAIT && needs_wait && ce_i && !power_fail && (!rdy || vdd_below_i))
    |=> q.st == ST_BOWAIT)
    else $error("start-up did not wait for detector");

  a_always_wake: assert property (
    (mode == MODE_ALWAYS && sleep_i) |-> wake_ok_o && brownout_enable_o)
    else $error("always-on mode lost protection in sleep");

  a_sleep_off: assert property (
    (mode == MODE_NOSLEEP) |-> brownout_enable_o == !sleep_i)
    else $error("off-in-sleep enable wrong");

  a_wake_wait: assert property (
    (mode == MODE_NOSLEEP && !rdy) |-> !wake_ok_o)
    else $error("wake allowed before detector ready");

  a_sw_nowait: assert property (
    (q.st == ST_BOWAIT && mode == MODE_SW && ce_i && !power_fail) |=> q.st == ST_PIN)
    else $error("software mode start-up waited");

  a_sw_ctrl: assert property (
    (mode == MODE_SW) |-> brownout_enable_o == q.sw_en)
    else $error("software enable ignored in mode 01");

  a_early_ready: assert property (
    (mode == MODE_ALWAYS && $rose(cpu_rst_n_o)) |-> brownout_circuit_ready_o)
    else $error("cpu ran before detector ready");

  a_fast_start: assert property (
    (mode == MODE_ALWAYS || mode == MODE_OFF) |-> !fs_eff)
    else $error("fast start acted in fixed mode");

  a_ready_read: assert property (
    (reg_req_i.rd && reg_hit && ce_i) |=> reg_rdata_o[RDY_BIT] == $past(rdy))
    else $error("ready bit read wrong");

  a_filt_gate: assert property (
    (filt_trip && rdy && ce_i) |=> q.st == ST_POR && !cpu_rst_n_o)
    else $error("ready detector trip did not reset");

  a_exit_end: assert property (
    (q.st == ST_EXIT && q.cnt == '0 && ce_i && !power_fail && !pin_low && !src_any)
    |=> q.st == ST_RUN)
    else $error("exit delay did not finish");

  a_exit_load: assert property (
    (q.st == ST_PIN && ce_i && !power_fail && !pin_low)
    |=> q.st == ST_EXIT && q.cnt == CNT_W'(EXIT_CYC - SYNC_LAT - 1))
    else $error("exit delay loaded wrong count");

  a_pin_holds: assert property (
    (q.st == ST_PIN && ce_i && !power_fail && pin_low) |=> q.st == ST_PIN)
    else $error("cpu let go while reset pin low");

  a_pud_count: assert property (
    (q.st == ST_PUD && q.cnt != '0 && ce_i && !power_fail)
    |=> q.st == ST_PUD && q.cnt == $past(q.cnt) - CNT_W'(1))
    else $error("power-up delay did not count down");

  a_ready_lost: assert property (
    (!bo_active && !fs_eff && ce_i) |=> q.rdy_cnt == '0)
    else $error("readiness kept without fast start");

  a_ready_kept: assert property (
    (!bo_active && fs_eff && ce_i) |=> $stable(q.rdy_cnt))
    else $error("readiness lost under fast start");

  a_ce_hold: assert property (
    (!ce_i && q.st == ST_PIN) |=> q.st == ST_PIN)
    else $error("sequencer moved with clock enable low");

  a_rdata_idle: assert property (
    (!reg_req_i.rd && ce_i) |=> reg_rdata_o == 8'h00)
    else $error("read data stood past its cycle");

  a_write_bits: assert property (
    (reg_req_i.wr && reg_hit && ce_i)
    |=> q.sw_en == $past(reg_req_i.wdata[SWEN_BIT]) && q.fs == $past(reg_req_i.wdata[FS_BIT]))
    else $error("control write not taken");

  a_run_stay: assert property (
    (q.st == ST_RUN && ce_i && !power_fail && !pin_low && !src_any) |=> q.st == ST_RUN)
    else $error("cpu dropped with no reset source");

  c_run: cover property (q.st == ST_EXIT ##1 q.st == ST_RUN);
  c_brownout: cover property (mode == MODE_ALWAYS && brownout_reset_o);
  c_wake_late: cover property (mode == MODE_NOSLEEP && $rose(wake_ok_o));
  c_pin_hold: cover property (q.st == ST_PIN ##1 q.st == ST_EXIT);
  c_sw_ready: cover property (mode == MODE_SW && $rose(brownout_circuit_ready_o));

endmodule

// *** testbench/brs_supply_model.sv ***
`timescale 1ns/1ps
module brs_supply_model (
  input  wire logic       sys_clk_i,
  input  wire logic       por_req_i,
  input  wire logic       sag_i,
  input  wire logic [7:0] dip_len_i,
  input  wire logic       dip_go_i,
  output logic            por_low_o,
  output logic            vdd_below_o
);
  // dips come in whole clock cycles, so filter counts stay exact
  logic [7:0] left_q = 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (dip_go_i) begin
      left_q <= dip_len_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  assign por_low_o   = por_req_i;
  assign vdd_below_o = sag_i || (left_q != 8'h00);
endmodule

// *** testbench/test_brownout_reset_sequencer.sv ***
`timescale 1ns/1ps
module test_brownout_reset_sequencer;
  import brs_pkg::*;
  // short counts keep the run small
  localparam int unsigned PUD = 50;
  localparam int unsigned FLT = 4;
  localparam int unsigned RDY = 5;
  localparam int unsigned EXT = 10;
  logic       sys_clk_i  = 1'b0;
  logic       resetn_i   = 1'b0;
  brs_req_t   req        = '0;
  brs_cfg_t   cfg        = '{2'h1, 1'b0, 1'b0, 1'b1, 1'b1};
  brs_src_t   src        = '0;
  logic       por_req    = 1'b1;
  logic       sag        = 1'b0;
  logic       dip_go     = 1'b0;
  logic [7:0] dip_len    = 8'h00;
  logic       lpb        = 1'b0;
  logic       pin_n      = 1'b1;
  logic       slp        = 1'b0;
  logic       ce         = 1'b1;
  logic       rd_seen    = 1'b0;
  logic [7:0] rdata;
  logic       por_low, vdd_below, cpu_n, bo_en, lvl, bg, rdy, bo_rst, wake;
  logic [7:0] exp_q[$];
  int         n_fail     = 0;
  int         num_checks = 0;
  int         cyc        = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  brs_supply_model supply (
    .sys_clk_i  (sys_clk_i),
    .por_req_i  (por_req),
    .sag_i      (sag),
    .dip_len_i  (dip_len),
    .dip_go_i   (dip_go),
    .por_low_o  (por_low),
    .vdd_below_o(vdd_below)
  );

  brs_top #(.PUD_CYC(PUD), .FILT_CYC(FLT), .RDY_CYC(RDY), .EXIT_CYC(EXT)) DUT (
    .sys_clk_i               (sys_clk_i),
    .resetn_i                (resetn_i),
    .ce_i                    (ce),
    .reg_req_i               (req),
    .reg_rdata_o             (rdata),
    .cfg_i                   (cfg),
    .por_low_i               (por_low),
    .vdd_below_i             (vdd_below),
    .low_power_brownout_i    (lpb),
    .external_reset_pin_n_i  (pin_n),
    .src_i                   (src),
    .sleep_i                 (slp),
    .cpu_rst_n_o             (cpu_n),
    .brownout_enable_o       (bo_en),
    .brownout_level_sel_o    (lvl),
    .bandgap_force_on_o      (bg),
    .brownout_circuit_ready_o(rdy),
    .brownout_reset_o        (bo_rst),
    .wake_ok_o               (wake)
  );

  ////////////////////////////////////////
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask

  task automatic lo(input string nm);
    @(negedge sys_clk_i);
    chk(nm, 8'h00, b(cpu_n));
  endtask

  // bounded wait for the cpu to be let go
  task automatic run_wait(input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (cpu_n !== 1'b1 && n < lim);
  endtask

  ////////////////////////////////////////
  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i) rd_seen <= req.rd;
  always @(negedge sys_clk_i) begin
    if (rd_seen) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      test_done;
    end
  end

  ////////////////////////////////////////
  initial begin
    int   n;
    logic hit;
    void'($urandom(78424));
    tick(4);
    resetn_i <= 1'b1;
    lo("por_hold");
    tick(RDY + 2);
    rd(4'h0, 8'h81);
    rd(4'h3, 8'h00);
    bus(4'h9, 8'($urandom()), 1'b1);
    bus(4'h0, 8'hff, 1'b1);
    rd(4'h0, 8'hc1);
    bus(4'h0, 8'h00, 1'b1);
    @(negedge sys_clk_i);
    chk("bo_en", 8'h00, b(bo_en));
    rd(4'h0, 8'h00);
    bus(4'h0, 8'h80, 1'b1);
    tick(RDY + 2);
    rd(4'h0, 8'h81);
    por_req <= 1'b0;
    run_wait(PUD + 60, n);
    chk("pud_len", 8'h01, b(n >= PUD && n < PUD + 40));
    tick(1);
    por_req <= 1'b1;
    cfg.powerup_delay_disable_n <= 1'b1;
    lo("por_again");
    tick(5);
    por_req <= 1'b0;
    run_wait(60, n);
    chk("nodelay_len", 8'(EXT + 3), 8'(n));
    tick(1);
    for (int c = 0; c < 2; c++) begin
      if (c == 1) tick(1);
      pin_n <= 1'b0;
      lo("pin");
      tick(20);
      pin_n <= 1'b1;
      // second release frozen five cycles by the clock enable
      ce    <= (c == 0);
      tick(5 * c);
      if (c == 1) ce <= 1'b1;
      run_wait(60, n);
      chk("pin_exit", 8'(EXT + 1), 8'(n));
    end
    for (int i = 0; i < 5; i++) begin
      tick(1);
      src <= brs_src_t'(5'(1 << i));
      lo("src");
      tick(1);
      src <= '0;
      run_wait(60, n);
      chk("src_rel", 8'h01, b(n >= 2 && n <= EXT + 6));
    end
    tick(1);
    lpb <= 1'b1;
    @(negedge sys_clk_i);
    chk("lp_trip", 8'h01, b(bo_rst & ~cpu_n));
    tick(1);
    lpb <= 1'b0;
    run_wait(60, n);
    for (int k = 0; k < 2; k++) begin
      tick(1);
      dip_len <= (k == 0) ? 8'($urandom_range(FLT, 1)) : 8'(FLT + 6);
      dip_go  <= 1'b1;
      tick(1);
      dip_go  <= 1'b0;
      hit = 1'b0;
      repeat (FLT + 8) begin
        @(negedge sys_clk_i);
        hit |= bo_rst & ~cpu_n;
      end
      chk("dip", b(k == 1), b(hit));
      run_wait(60, n);
    end
    for (int f = 0; f < 2; f++) begin
      bus(4'h0, {1'b1, f[0], 6'h00}, 1'b1);
      for (int m = 0; m < 4; m++) begin
        for (int s = 0; s < 2; s++) begin
          tick(1);
          cfg.brownout_mode_sel  <= m[1:0];
          cfg.brownout_level_sel <= s[0];
          slp                    <= s[0];
          tick(RDY + 3);
          @(negedge sys_clk_i);
          hit = (m == 3) || (m == 2 && s == 0) || m == 1;
          chk("bo_en", b(hit), b(bo_en));
          chk("lvl", b(s[0]), b(lvl));
          chk("bg", b(hit || (f == 1 && (m == 1 || m == 2))), b(bg));
          if (f == 0) chk("rdy", b(hit), b(rdy));
          if (m == 3) chk("wake", 8'h01, b(wake));
          if (m == 2 && f == 0) chk("wake", b(s == 0), b(wake));
        end
      end
    end
    // a sagging supply must keep the forced-on modes in reset
    for (int m = 2; m < 4; m++) begin
      tick(1);
      cfg.brownout_mode_sel <= m[1:0];
      slp     <= 1'b0;
      sag     <= 1'b1;
      por_req <= 1'b1;
      tick(2);
      por_req <= 1'b0;
      hit = 1'b0;
      repeat (30) begin
        @(negedge sys_clk_i);
        hit |= cpu_n;
      end
      chk("bo_wait", 8'h00, b(hit));
      tick(1);
      sag <= 1'b0;
      run_wait(80, n);
      chk("bo_go", 8'h01, b(n < 80));
    end
    test_done;
  end
endmodule
